// ===== core/rco_pkg.sv
// Register map, field positions and reset values of the remote control carrier output
package rco_pkg;
	localparam int DW = 16;
	localparam int AW = 8;
	localparam int NPAIR = 2;
	localparam int NCH = 4;
	// Register byte offsets
	localparam logic [7:0] PERIPHERAL_ENABLE_REG_OFF = 8'h00;
	localparam logic [7:0] PRESCALER_SELECT_REG_OFF = 8'h04;
	localparam logic [7:0] TIMER_OUTPUT_SELECT_REG_OFF = 8'h08;
	localparam logic [7:0] PORT3_REG_OFF = 8'h0c;
	localparam logic [7:0] OUT_MODE_REG_OFF = 8'h30;
	localparam logic [7:0] OUT_POLARITY_REG_OFF = 8'h34;
	localparam logic [7:0] OUT_LEVEL_REG_OFF = 8'h38;
	localparam logic [7:0] OUT_ENABLE_REG_OFF = 8'h3c;
	localparam logic [7:0] START_REG_OFF = 8'h40;
	localparam logic [7:0] STOP_REG_OFF = 8'h44;
	localparam logic [7:0] RUN_STATUS_REG_OFF = 8'h48;
	localparam logic [7:0] MASK_COUNTER_REG_OFF = 8'h4c;
	// Pair blocks: pair 0 at 10h, pair 1 at 20h; a[3:2] picks the word
	localparam logic [3:0] PAIR0_BLOCK = 4'h1;
	localparam logic [3:0] PAIR1_BLOCK = 4'h2;
	localparam logic [1:0] SUB_MASTER_MODE = 2'h0;
	localparam logic [1:0] SUB_SLAVE_MODE = 2'h1;
	localparam logic [1:0] SUB_PERIOD = 2'h2;
	localparam logic [1:0] SUB_WIDTH = 2'h3;
	// Field positions
	localparam int UNIT_EN_BIT = 0;
	localparam int REMOTE_SEL_BIT = 0;
	localparam int CLOCK_SEL_BIT = 15;
	localparam int SEG_FN_BIT = 0;
	localparam int REMOTE_DIR_BIT = 1;
	localparam int REMOTE_LATCH_BIT = 2;
	localparam int PULLUP_BIT = 3;
	localparam int CARRIER_DIR_BIT = 4;
	localparam int CARRIER_LATCH_BIT = 5;
	localparam int MASK_CH = 1;
	localparam int CARRIER_CH = 3;
	// Reset values: both pins input, latches low
	localparam logic [5:0] PORT3_RESET = 6'h12;
	localparam logic [7:0] PRESCALER_RESET = 8'h00;
	// Mode values software writes to select PWM operation
	localparam logic [15:0] MASTER_PWM_MODE = 16'h0801;
	localparam logic [15:0] SLAVE_PWM_MODE = 16'h0409;
endpackage

// ===== core/rco_remote_out.sv
// Remote control output: two PWM pairs whose slave outputs are ANDed onto one pin
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Channels 2/3 and 6/7 run as two master/slave PWM pairs.
// - Remote pin carries AND of mask (channel 3) and carrier (channel 7).
// - After pin setup, before select bit, remote pin drives low.
// - Unit enable clear: timer unit gets no clock and ignores writes.
// - Unit enable set: clock runs, writes taken, all channels stopped.
// - Prescaler select sets the rates of count clocks a and b.
// - Select bit set: pin shows AND of mask and carrier, low at first.
// - Select bit set: mask pin works only as remote output.
// - Select bit set: carrier pin loses timer role, serves other function.
// - Master output mode 0, slave output mode 1 selects PWM output behaviour.
// - Level bit sets default; pin high-Z until direction output and latch 0.
// - Setting output enable while stopped leaves the output unchanged.
// - With latch and direction cleared the pin drives the programmed level.
// - Mask master raises its interrupt each time its counter hits zero.
module rco_remote_out (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [rco_pkg::AW-1:0] addr,
	input wire logic [rco_pkg::DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [rco_pkg::DW-1:0] rdata,
	output logic mask_period_interrupt,
	output logic remote_pin_out,
	output logic remote_pin_oe,
	output logic carrier_pin_out,
	output logic carrier_pin_oe,
	output logic port3_pullup_bit
);
	import rco_pkg::*;

	logic timer_unit_enable, remote_output_select_bit;
	logic [5:0] port3_reg;
	logic [7:0] prescaler_select_reg;
	logic [15:0] master_mode_reg [NPAIR];
	logic [15:0] slave_mode_reg [NPAIR];
	logic [15:0] period_reg [NPAIR];
	logic [15:0] width_reg [NPAIR];
	logic [15:0] master_cnt [NPAIR], slave_cnt [NPAIR];
	logic [NCH-1:0] out_mode, out_pol, out_level, out_en;
	logic [NPAIR-1:0] run, master_evt, master_tick, slave_tick;
	logic [15:0] prescale_cnt;
	logic count_clock_a, count_clock_b;
	logic timer_wr, start_wr, stop_wr, level_wr, and_now;

	// True for a word-aligned address inside one of the two pair blocks
	function automatic logic pair_hit(input logic [AW-1:0] a);
		return (a[7:4] == PAIR0_BLOCK || a[7:4] == PAIR1_BLOCK) && a[1:0] == 2'h0;
	endfunction

	// Index of the pair that an address in a pair block belongs to
	function automatic int pair_of(input logic [AW-1:0] a);
		return (a[7:4] == PAIR1_BLOCK) ? 1 : 0;
	endfunction

	// Tick once every 2^sel cycles of the free prescaler counter
	function automatic logic div_tick(input logic [15:0] cnt, input logic [3:0] sel);
		logic [15:0] m;
		m = 16'hffff >> (5'd16 - {1'b0, sel});
		return (cnt & m) == m;
	endfunction

	// Pick count clock a or b from a channel mode register
	function automatic logic pick_clock(input logic [15:0] mode, input logic a, input logic b);
		return mode[CLOCK_SEL_BIT] ? b : a;
	endfunction

	// Write strobes of the timer unit are ignored while it is unclocked
	assign timer_wr = wr && timer_unit_enable;
	assign start_wr = timer_wr && addr == START_REG_OFF;
	assign stop_wr = timer_wr && addr == STOP_REG_OFF;
	assign level_wr = timer_wr && addr == OUT_LEVEL_REG_OFF;
	assign and_now = out_level[MASK_CH] & out_level[CARRIER_CH];
	assign mask_period_interrupt = master_evt[0];

	// Unit enable, output select and port bits stay writable at all times
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timer_unit_enable <= 1'b0;
			remote_output_select_bit <= 1'b0;
			port3_reg <= PORT3_RESET;
		end else if (wr) begin
			if (addr == PERIPHERAL_ENABLE_REG_OFF) begin
				timer_unit_enable <= wdata[UNIT_EN_BIT];
			end else if (addr == TIMER_OUTPUT_SELECT_REG_OFF) begin
				remote_output_select_bit <= wdata[REMOTE_SEL_BIT];
			end else if (addr == PORT3_REG_OFF) begin
				port3_reg <= wdata[5:0];
			end
		end
	end

	// Timer configuration; held at reset values while the unit is off
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prescaler_select_reg <= PRESCALER_RESET;
			out_mode <= '0;
			out_pol <= '0;
			out_en <= '0;
			for (int p = 0; p < NPAIR; p++) begin
				master_mode_reg[p] <= '0;
				slave_mode_reg[p] <= '0;
				period_reg[p] <= '0;
				width_reg[p] <= '0;
			end
		end else if (!timer_unit_enable) begin
			prescaler_select_reg <= PRESCALER_RESET;
			out_mode <= '0;
			out_pol <= '0;
			out_en <= '0;
			for (int p = 0; p < NPAIR; p++) begin
				master_mode_reg[p] <= '0;
				slave_mode_reg[p] <= '0;
				period_reg[p] <= '0;
				width_reg[p] <= '0;
			end
		end else if (timer_wr) begin
			if (addr == PRESCALER_SELECT_REG_OFF) begin
				prescaler_select_reg <= wdata[7:0];
			end else if (addr == OUT_MODE_REG_OFF) begin
				out_mode <= wdata[NCH-1:0];
			end else if (addr == OUT_POLARITY_REG_OFF) begin
				out_pol <= wdata[NCH-1:0];
			end else if (addr == OUT_ENABLE_REG_OFF) begin
				out_en <= wdata[NCH-1:0];
			end else if (pair_hit(addr)) begin
				// Mode values such as 0801h and 0409h are stored as written
				case (addr[3:2])
					SUB_MASTER_MODE: master_mode_reg[pair_of(addr)] <= wdata;
					SUB_SLAVE_MODE: slave_mode_reg[pair_of(addr)] <= wdata;
					SUB_PERIOD: period_reg[pair_of(addr)] <= wdata;
					default: width_reg[pair_of(addr)] <= wdata;
				endcase
			end
		end
	end

	// Prescaler: free counter and the two count clock ticks
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prescale_cnt <= '0;
			count_clock_a <= 1'b0;
			count_clock_b <= 1'b0;
		end else if (!timer_unit_enable) begin
			prescale_cnt <= '0;
			count_clock_a <= 1'b0;
			count_clock_b <= 1'b0;
		end else begin
			prescale_cnt <= prescale_cnt + 16'h1;
			count_clock_a <= div_tick(prescale_cnt, prescaler_select_reg[3:0]);
			count_clock_b <= div_tick(prescale_cnt, prescaler_select_reg[7:4]);
		end
	end

	// Count clock seen by each master and slave channel
	always_comb begin
		for (int p = 0; p < NPAIR; p++) begin
			master_tick[p] = pick_clock(master_mode_reg[p], count_clock_a, count_clock_b);
			slave_tick[p] = pick_clock(slave_mode_reg[p], count_clock_a, count_clock_b);
		end
	end

	// PWM pairs: master sets the period, slave the high width
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run <= '0;
			master_evt <= '0;
			out_level <= '0;
			for (int p = 0; p < NPAIR; p++) begin
				master_cnt[p] <= '0;
				slave_cnt[p] <= '0;
			end
		end else if (!timer_unit_enable) begin
			run <= '0;
			master_evt <= '0;
			out_level <= '0;
			for (int p = 0; p < NPAIR; p++) begin
				master_cnt[p] <= '0;
				slave_cnt[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NPAIR; p++) begin
				master_evt[p] <= 1'b0;
				if (start_wr && wdata[p]) begin
					run[p] <= 1'b1;
					master_cnt[p] <= period_reg[p];
					master_evt[p] <= 1'b1;
				end else if (stop_wr && wdata[p]) begin
					run[p] <= 1'b0; // Counters and levels hold
				end else if (run[p] && master_tick[p]) begin
					if (master_cnt[p] == 16'h0) begin
						master_cnt[p] <= period_reg[p];
						master_evt[p] <= 1'b1;
					end else begin
						master_cnt[p] <= master_cnt[p] - 16'h1;
					end
				end
				// Slave reloads on the master event (zero width for a zero period), active on its next tick
				if (master_evt[p]) begin
					slave_cnt[p] <= (period_reg[p] == 16'h0) ? 16'h0 : width_reg[p];
				end else if (run[p] && slave_tick[p] && out_en[2*p+1] && out_mode[2*p+1]) begin
					out_level[2*p+1] <= (slave_cnt[p] != 16'h0) ^ out_pol[2*p+1];
					if (slave_cnt[p] != 16'h0) begin
						slave_cnt[p] <= slave_cnt[p] - 16'h1;
					end
				end
			end
			// Software sets the default level only of outputs not yet enabled
			if (level_wr) begin
				for (int i = 0; i < NCH; i++) begin
					if (!out_en[i]) begin
						out_level[i] <= wdata[i];
					end
				end
			end
		end
	end

	// Pin multiplexing for the remote pin and the carrier pin
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			remote_pin_out <= 1'b0;
			remote_pin_oe <= 1'b0;
			carrier_pin_out <= 1'b0;
			carrier_pin_oe <= 1'b0;
			port3_pullup_bit <= 1'b0;
		end else begin
			port3_pullup_bit <= port3_reg[PULLUP_BIT];
			if (remote_output_select_bit) begin
				remote_pin_oe <= 1'b1;
				remote_pin_out <= and_now;
				carrier_pin_oe <= !port3_reg[CARRIER_DIR_BIT];
				carrier_pin_out <= port3_reg[CARRIER_LATCH_BIT];
			end else begin
				// Ordinary timer pins; counters untouched by the select bit
				if (port3_reg[SEG_FN_BIT]) begin
					remote_pin_oe <= 1'b1;
					remote_pin_out <= 1'b0;
				end else begin
					remote_pin_oe <= !port3_reg[REMOTE_DIR_BIT] && !port3_reg[REMOTE_LATCH_BIT];
					remote_pin_out <= out_level[MASK_CH];
				end
				carrier_pin_oe <= !port3_reg[CARRIER_DIR_BIT] && !port3_reg[CARRIER_LATCH_BIT];
				carrier_pin_out <= out_level[CARRIER_CH];
			end
		end
	end

	// Read data, valid in the cycle after the read strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= '0;
		end else begin
			rdata <= '0;
			if (rd) begin
				if (addr == PERIPHERAL_ENABLE_REG_OFF) begin
					rdata <= {15'h0, timer_unit_enable};
				end else if (addr == PRESCALER_SELECT_REG_OFF) begin
					rdata <= {8'h0, prescaler_select_reg};
				end else if (addr == TIMER_OUTPUT_SELECT_REG_OFF) begin
					rdata <= {15'h0, remote_output_select_bit};
				end else if (addr == PORT3_REG_OFF) begin
					rdata <= {10'h0, port3_reg};
				end else if (addr == OUT_MODE_REG_OFF) begin
					rdata <= {12'h0, out_mode};
				end else if (addr == OUT_POLARITY_REG_OFF) begin
					rdata <= {12'h0, out_pol};
				end else if (addr == OUT_LEVEL_REG_OFF) begin
					rdata <= {12'h0, out_level};
				end else if (addr == OUT_ENABLE_REG_OFF) begin
					rdata <= {12'h0, out_en};
				end else if (addr == RUN_STATUS_REG_OFF) begin
					rdata <= {14'h0, run};
				end else if (addr == MASK_COUNTER_REG_OFF) begin
					rdata <= master_cnt[0];
				end else if (pair_hit(addr)) begin
					case (addr[3:2])
						SUB_MASTER_MODE: rdata <= master_mode_reg[pair_of(addr)];
						SUB_SLAVE_MODE: rdata <= slave_mode_reg[pair_of(addr)];
						SUB_PERIOD: rdata <= period_reg[pair_of(addr)];
						default: rdata <= width_reg[pair_of(addr)];
					endcase
				end
			end
		end
	end

	// Start of the mask pair by software
	sequence mask_start_s;
		start_wr && wdata[0];
	endsequence
	// Mask master counter expiring on a count tick
	sequence mask_zero_s;
		run[0] && master_tick[0] && master_cnt[0] == 16'h0 && !start_wr && !stop_wr;
	endsequence

	start_pair_a: assert property (@(posedge clk) disable iff (!nrst)
		mask_start_s |=> run[0] && mask_period_interrupt && master_cnt[0] == $past(period_reg[0]))
		else $error("mask pair did not start");
	zero_irq_a: assert property (@(posedge clk) disable iff (!nrst)
		mask_zero_s |=> mask_period_interrupt ##1 !mask_period_interrupt)
		else $error("mask interrupt not one pulse at zero");
	remote_and_a: assert property (@(posedge clk) disable iff (!nrst)
		remote_output_select_bit |=> remote_pin_oe && remote_pin_out == $past(and_now))
		else $error("remote pin is not mask AND carrier");
	idle_low_a: assert property (@(posedge clk) disable iff (!nrst)
		!remote_output_select_bit && port3_reg[SEG_FN_BIT] |=> remote_pin_oe && !remote_pin_out)
		else $error("remote pin not low before select");
	unit_off_a: assert property (@(posedge clk) disable iff (!nrst)
		!timer_unit_enable |=> run == 2'h0 && prescaler_select_reg == PRESCALER_RESET)
		else $error("timer unit active while disabled");
	stopped_on_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(timer_unit_enable) |-> run == 2'h0 && out_level == 4'h0)
		else $error("channels not stopped at enable");
	slave_level_a: assert property (@(posedge clk) disable iff (!nrst)
		run[1] && slave_tick[1] && out_en[3] && out_mode[3] && !master_evt[1] && slave_cnt[1] != 16'h0 && !level_wr
		|=> out_level[3] == !out_pol[3])
		else $error("carrier slave not active while counting");
	enable_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		timer_wr && addr == OUT_ENABLE_REG_OFF && run == 2'h0 |=> $stable(out_level))
		else $error("output changed on enable while stopped");
	pin_level_a: assert property (@(posedge clk) disable iff (!nrst)
		!remote_output_select_bit && port3_reg[2:0] == 3'h0
		|=> remote_pin_oe && remote_pin_out == $past(out_level[MASK_CH]))
		else $error("remote pin not driving programmed level");
	carrier_free_a: assert property (@(posedge clk) disable iff (!nrst)
		remote_output_select_bit |=> carrier_pin_out == $past(port3_reg[CARRIER_LATCH_BIT]))
		else $error("carrier pin still timer driven");
endmodule

// ===== tb/rco_ir_led.sv
// Infrared LED driver model standing on the remote output pin
`timescale 1ns/1ps
module rco_ir_led (
	input wire logic clk,
	input wire logic nrst,
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic pull_en,
	output logic pin_level,
	output logic led_on
);
	logic last;
	// Undriven wire floats to the pull-up, or to a value the bench cannot mistake for the last one
	always_comb begin
		if (pin_oe) begin
			pin_level = pin_out;
		end else if (pull_en) begin
			pin_level = 1'b1;
		end else begin
			pin_level = ~last;
		end
	end
	// Remember the level last seen on the wire
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			last <= 1'b0;
		end else begin
			last <= pin_level;
		end
	end
	// LED lights only while the pin really drives high
	assign led_on = pin_oe & pin_out;
endmodule

// ===== tb/remote_control_carrier_output_tb_top.sv
// Self-checking bench for the remote control carrier output
`timescale 1ns/1ps
module remote_control_carrier_output_tb_top;
	import rco_pkg::*;
	logic clk, nrst, wr, rd, rd_d1;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata;
	logic mask_period_interrupt, remote_pin_out, remote_pin_oe, carrier_pin_out, carrier_pin_oe;
	logic port3_pullup_bit, pin_level, led_on;
	logic [15:0] expq[$];
	int n_fail = 0;
	int compares = 0;
	int seed, t, n;
	logic [31:0] r;
	rco_remote_out dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.mask_period_interrupt(mask_period_interrupt), .remote_pin_out(remote_pin_out),
		.remote_pin_oe(remote_pin_oe), .carrier_pin_out(carrier_pin_out), .carrier_pin_oe(carrier_pin_oe),
		.port3_pullup_bit(port3_pullup_bit));
	rco_ir_led led_u (.clk(clk), .nrst(nrst), .pin_out(remote_pin_out), .pin_oe(remote_pin_oe),
		.pull_en(port3_pullup_bit), .pin_level(pin_level), .led_on(led_on));
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Compare one value and count it
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Verdict and end of run
	task results;
		if (n_fail == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One-cycle register write
	task wr_r(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// One-cycle register read; the expected data wait in the queue
	task rd_r(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		expq.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_d1 <= rd;
		if (rd_d1 === 1'b1) begin
			chk("rdata", rdata, expq.pop_front());
		end
	end
	// Pins settle one edge after the write is taken
	task chk_pin(input logic [3:0] e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("pins", {12'h0, remote_pin_oe, remote_pin_out, carrier_pin_oe, carrier_pin_out}, {12'h0, e});
	endtask
	// Cycles up to the next interrupt pulse, bounded
	task wait_irq(output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (mask_period_interrupt !== 1'b1 && c < 3000);
		if (c >= 3000) begin
			n_fail++;
			results();
		end
	endtask
	// High cycles over a window, remote wire or carrier pin
	task cnt_hi(input bit car, input int len, output int c);
		c = 0;
		repeat (len) begin
			@(negedge clk);
			if (car ? (carrier_pin_oe === 1'b1 && carrier_pin_out === 1'b1) : (pin_level === 1'b1))
				c++;
		end
	endtask
	function automatic logic [7:0] pa(input int p, input logic [1:0] sub);
		return {(p == 1) ? PAIR1_BLOCK : PAIR0_BLOCK, sub, 2'b00};
	endfunction
	// Main sequence
	initial begin
		seed = 32'h972a8b33;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		nrst = 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk("pins_reset", {12'h0, remote_pin_oe, remote_pin_out, carrier_pin_oe, carrier_pin_out}, 16'h0);
		rd_r(PORT3_REG_OFF, {10'h0, PORT3_RESET});
		rd_r(8'hf0, 16'h0);
		r = $random(seed);
		// Timer writes with the unit off are dropped
		wr_r(PRESCALER_SELECT_REG_OFF, r[15:0]);
		wr_r(pa(0, SUB_PERIOD), r[31:16]);
		rd_r(PRESCALER_SELECT_REG_OFF, 16'h0);
		rd_r(pa(0, SUB_PERIOD), 16'h0);
		// Pin mode: segment, direction, latch and pull-up set
		wr_r(PORT3_REG_OFF, 16'h000f);
		chk_pin(4'b1010);
		chk("pullup", {15'h0, port3_pullup_bit}, 16'h1);
		// Unit on, channels stopped, prescaler stored
		wr_r(PERIPHERAL_ENABLE_REG_OFF, 16'h1);
		rd_r(PERIPHERAL_ENABLE_REG_OFF, 16'h1);
		rd_r(RUN_STATUS_REG_OFF, 16'h0);
		wr_r(PRESCALER_SELECT_REG_OFF, {8'h0, r[7:0]});
		rd_r(PRESCALER_SELECT_REG_OFF, {8'h0, r[7:0]});
		wr_r(PRESCALER_SELECT_REG_OFF, 16'h0);
		// Both pairs as PWM: mask period 16 high 8, carrier period 4 high 2
		for (int p = 0; p < NPAIR; p++) begin
			wr_r(pa(p, SUB_MASTER_MODE), MASTER_PWM_MODE);
			wr_r(pa(p, SUB_SLAVE_MODE), SLAVE_PWM_MODE);
			wr_r(pa(p, SUB_PERIOD), (p == 0) ? 16'h000f : 16'h0003);
			wr_r(pa(p, SUB_WIDTH), (p == 0) ? 16'h0008 : 16'h0002);
			rd_r(pa(p, SUB_MASTER_MODE), MASTER_PWM_MODE);
			rd_r(pa(p, SUB_SLAVE_MODE), SLAVE_PWM_MODE);
		end
		wr_r(OUT_MODE_REG_OFF, 16'h000a);
		rd_r(OUT_MODE_REG_OFF, 16'h000a);
		wr_r(OUT_POLARITY_REG_OFF, 16'h0000);
		// Default levels: mask high, carrier low
		wr_r(OUT_LEVEL_REG_OFF, 16'h0002);
		wr_r(PORT3_REG_OFF, 16'h0002);
		chk_pin(4'b0110);
		wr_r(PORT3_REG_OFF, 16'h0000);
		chk_pin(4'b1110);
		chk("led", {15'h0, led_on}, 16'h1);
		wr_r(OUT_ENABLE_REG_OFF, 16'h000f);
		wr_r(OUT_LEVEL_REG_OFF, 16'h0000);
		rd_r(OUT_LEVEL_REG_OFF, 16'h0002);
		chk_pin(4'b1110);
		// Remote select: AND of high mask and low carrier is low
		wr_r(TIMER_OUTPUT_SELECT_REG_OFF, 16'h0001);
		chk_pin(4'b1010);
		wr_r(PORT3_REG_OFF, 16'h0022);
		chk_pin(4'b1011);
		wr_r(PORT3_REG_OFF, 16'h0000);
		// Run both pairs from one start
		wr_r(START_REG_OFF, 16'h0003);
		wait_irq(t);
		wait_irq(t);
		wait_irq(t);
		chk("irq_gap", t[15:0], 16'd16);
		cnt_hi(1'b0, 16, n);
		chk("and_high", n[15:0], 16'd4);
		wr_r(TIMER_OUTPUT_SELECT_REG_OFF, 16'h0000);
		repeat (2) @(posedge clk);
		cnt_hi(1'b0, 16, n);
		chk("mask_high", n[15:0], 16'd8);
		cnt_hi(1'b1, 16, n);
		chk("carrier_high", n[15:0], 16'd8);
		rd_r(RUN_STATUS_REG_OFF, 16'h0003);
		// Count clock a halved doubles the mask period
		wr_r(STOP_REG_OFF, 16'h0003);
		wr_r(PRESCALER_SELECT_REG_OFF, 16'h0001);
		wr_r(START_REG_OFF, 16'h0003);
		wait_irq(t);
		wait_irq(t);
		wait_irq(t);
		chk("irq_gap_div2", t[15:0], 16'd32);
		// Zero mask period ends the code with the output low
		wr_r(TIMER_OUTPUT_SELECT_REG_OFF, 16'h0001);
		wr_r(pa(0, SUB_PERIOD), 16'h0000);
		repeat (80) @(posedge clk);
		cnt_hi(1'b0, 32, n);
		chk("stopped_low", n[15:0], 16'd0);
		// Carrier alone, count clock a divided by 2048: 8192-cycle period, about 30.5 kHz
		wr_r(STOP_REG_OFF, 16'h0003);
		wr_r(TIMER_OUTPUT_SELECT_REG_OFF, 16'h0000);
		wr_r(PRESCALER_SELECT_REG_OFF, 16'h000b);
		wr_r(START_REG_OFF, 16'h0002);
		repeat (4096) @(posedge clk);
		cnt_hi(1'b1, 8192, n);
		chk("carrier_30khz", n[15:0], 16'd4096);
		// Unit off clears the timer registers
		wr_r(PERIPHERAL_ENABLE_REG_OFF, 16'h0);
		rd_r(pa(0, SUB_MASTER_MODE), 16'h0);
		repeat (3) @(posedge clk);
		results();
	end
endmodule
